/* rtl/nsrcg_pkg.sv */
// Package for the NAND status, reset and command guard block.
// Assumes a 50 MHz system clock; shared by all block files except the synchroniser.
package nsrcg_pkg;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_CB_READ = 8'h35;
	localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
	localparam logic [7:0] CMD_COL_CHG = 8'h85;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ECC_STATUS = 8'h7A;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam int ST_FAIL_BIT = 0;
	localparam int ST_REWRITE_BIT = 3;
	localparam int ST_RDY_A_BIT = 5;
	localparam int ST_RDY_B_BIT = 6;
	localparam int ST_WP_BIT = 7;
	localparam int ECC_SECTORS = 4;
	localparam int SECT_W = 2;
	localparam int SECT_MAIN_BYTES = 512;
	localparam int SECT_SPARE_BYTES = 16;
	localparam logic [3:0] ECC_MAX_BITS = 4'h8;
	localparam logic [3:0] ECC_CODE_UNC = 4'hF;
	localparam logic [3:0] REWRITE_LEVEL = 4'h6;
	localparam int CLK_PERIOD_NS = 20;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES =
		(INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] PIN_RST = 5'h0F;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_RD_SETUP = 3'b001,
		M_RD_DATA = 3'b010,
		M_PROG = 3'b011,
		M_ERASE = 3'b100,
		M_STATUS = 3'b101,
		M_ECC = 3'b110
	} nsrcg_mode_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_READ = 2'b01,
		OP_PROG = 2'b10,
		OP_ERASE = 2'b11
	} nsrcg_op_e;
endpackage

/* rtl/nsrcg_ecc_if.sv */
// Interface carrying captured ECC results to the ECC byte formatter.
// Assumes both ends share clk_sys; the formatter is combinational.
`timescale 1ns/1ps
interface nsrcg_ecc_if;
	import nsrcg_pkg::*;
	logic [4*ECC_SECTORS-1:0] err_cnt;
	logic [ECC_SECTORS-1:0] unc;
	logic [SECT_W-1:0] sel;
	logic [7:0] code_byte;
	logic any_unc;
	logic any_rewrite;
	modport ctl (output err_cnt, unc, sel,
		input code_byte, any_unc, any_rewrite);
	modport fmt (input err_cnt, unc, sel,
		output code_byte, any_unc, any_rewrite);
endinterface

/* rtl/nsrcg_sync.sv */
// Two-stage synchroniser for pin inputs.
// Assumes asynchronous inputs; stage one feeds only stage two.
`timescale 1ns/1ps
module nsrcg_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end
		else if (clk_en)
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* rtl/nsrcg_ecc_fmt.sv */
// Encodes per-sector ECC results into the ECC status byte.
// Assumes counts are held stable by the controller between reads.
`timescale 1ns/1ps
module nsrcg_ecc_fmt (
	nsrcg_ecc_if.fmt e
);
	import nsrcg_pkg::*;
	logic [3:0] code [ECC_SECTORS];
	logic [ECC_SECTORS-1:0] unc_v;
	logic [ECC_SECTORS-1:0] rew_v;

	// One ECC sector is 512 main plus 16 spare bytes, four per page
	for (genvar i = 0; i < ECC_SECTORS; i++)
	begin : g_sect
		logic [3:0] cnt;
		assign cnt = e.err_cnt[4*i +: 4];
		// Beyond eight bits the sector cannot be repaired
		assign unc_v[i] = e.unc[i] || (cnt > ECC_MAX_BITS);
		assign code[i] = unc_v[i] ? ECC_CODE_UNC : cnt;
		assign rew_v[i] = !unc_v[i] && (cnt >= REWRITE_LEVEL);
	end

	assign e.any_unc = |unc_v;
	assign e.any_rewrite = |rew_v;
	assign e.code_byte = {4'(e.sel), code[e.sel]};
endmodule

/* rtl/nsrcg_top.sv */
// Status, ECC status, reset and command guard of a NAND flash device.
// Assumes host pins are asynchronous and the internal engines share clk_sys.
`timescale 1ns/1ps
module nsrcg_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cle,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic ready_busy_n_pin_out,
	output logic ready_busy_n_pin_oe,
	input wire logic eng_busy,
	input wire logic eng_done,
	input wire logic eng_fail,
	input wire logic [4*nsrcg_pkg::ECC_SECTORS-1:0] eng_err_cnt,
	input wire logic [nsrcg_pkg::ECC_SECTORS-1:0] eng_unc,
	output logic eng_start,
	output nsrcg_pkg::nsrcg_op_e eng_op,
	output logic eng_abort
);
	import nsrcg_pkg::*;

	logic [4:0] pins_s;
	logic [7:0] io_s;
	logic cle_s, ce_n_s, we_s, re_s, wp_s;
	logic we_d, re_d, wp_d;
	logic cmd_strobe, cmd_ok, known, re_rise, busy;
	logic [7:0] cmd;
	logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
	nsrcg_mode_e mode;
	nsrcg_op_e cur_op, res_op;
	logic rd_resume, res_fail;
	logic [7:0] status_byte;
	logic start_ok;
	nsrcg_op_e start_op;
	nsrcg_ecc_if ecc ();

	nsrcg_sync #(.W(5), .RST_VAL(PIN_RST)) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({cle, ce_n, we_n, read_strobe_n, wp_n}),
		.q(pins_s)
	);

	nsrcg_sync #(.W(8), .RST_VAL(8'h00)) u_io_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d(io_in),
		.q(io_s)
	);

	nsrcg_ecc_fmt u_fmt (
		.e(ecc.fmt)
	);

	assign {cle_s, ce_n_s, we_s, re_s, wp_s} = pins_s;
	assign cmd = io_s;
	assign cmd_strobe = cle_s && !ce_n_s && we_s && !we_d;
	assign re_rise = !ce_n_s && re_s && !re_d;
	assign busy = (init_cnt != '0) || eng_busy;

	always_comb
	begin
		case (cmd)
			CMD_READ, CMD_READ_GO, CMD_CB_READ, CMD_SERIAL_IN,
			CMD_COL_CHG, CMD_PROG_GO, CMD_ERASE_SETUP, CMD_ERASE_GO,
			CMD_STATUS, CMD_ECC_STATUS, CMD_ID, CMD_RESET:
				known = 1'b1;
			default:
				known = 1'b0;
		endcase
	end

	// Unknown codes, and codes other than status and reset while busy, are dropped
	assign cmd_ok = cmd_strobe && (cmd == CMD_RESET
		|| cmd == CMD_STATUS || (known && !busy));

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			we_d <= 1'b1;
			re_d <= 1'b1;
			wp_d <= 1'b1;
		end
		else if (clk_en)
		begin
			we_d <= we_s;
			re_d <= re_s;
			wp_d <= wp_s;
		end
	end

	// Power-on initialisation window, counted from reset release
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			init_cnt <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES);
		else if (clk_en && init_cnt != '0)
			init_cnt <= init_cnt - 1'b1;
	end

	always_comb
	begin
		start_ok = 1'b0;
		start_op = OP_NONE;
		if (cmd_ok)
		begin
			if ((cmd == CMD_READ_GO || cmd == CMD_CB_READ)
				&& mode == M_RD_SETUP)
			begin
				start_ok = 1'b1;
				start_op = OP_READ;
			end
			else if (cmd == CMD_PROG_GO && mode == M_PROG && wp_s)
			begin
				start_ok = 1'b1;
				start_op = OP_PROG;
			end
			else if (cmd == CMD_ERASE_GO && mode == M_ERASE && wp_s)
			begin
				start_ok = 1'b1;
				start_op = OP_ERASE;
			end
		end
	end

	// Command mode tracking; a new command replaces the old mode, but 30h/35h act only in read setup
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			mode <= M_IDLE;
			rd_resume <= 1'b0;
		end
		else if (clk_en)
		begin
			if (cmd_ok)
			begin
				case (cmd)
					CMD_RESET:
					begin
						mode <= M_IDLE;
						rd_resume <= 1'b0;
					end
					CMD_STATUS:
						mode <= M_STATUS;
					CMD_ECC_STATUS:
						mode <= M_ECC;
					CMD_READ:
					begin
						// Return to data out without a new address
						if (mode == M_STATUS && rd_resume)
							mode <= M_RD_DATA;
						else
						begin
							mode <= M_RD_SETUP;
							rd_resume <= 1'b0;
						end
					end
					CMD_READ_GO, CMD_CB_READ:
					begin
						if (mode == M_RD_SETUP)
						begin
							mode <= M_RD_DATA;
							rd_resume <= 1'b1;
						end
					end
					CMD_SERIAL_IN, CMD_COL_CHG:
						mode <= M_PROG;
					CMD_ERASE_SETUP:
						mode <= M_ERASE;
					default:
						mode <= M_IDLE;
				endcase
			end
			else if (!wp_s && (mode == M_PROG || mode == M_ERASE))
				mode <= M_IDLE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			eng_start <= 1'b0;
			eng_op <= OP_NONE;
			cur_op <= OP_NONE;
		end
		else if (clk_en)
		begin
			eng_start <= start_ok;
			if (start_ok)
			begin
				eng_op <= start_op;
				cur_op <= start_op;
			end
		end
	end

	// Abort also discharges program/erase; the engine ends in wait state
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			eng_abort <= 1'b0;
		else if (clk_en)
			eng_abort <= eng_busy && ((cmd_ok && cmd == CMD_RESET)
				|| (!wp_s && wp_d && cur_op != OP_READ));
	end

	// Results hold until a new operation starts; done wins a tie
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			res_op <= OP_NONE;
			res_fail <= 1'b0;
			ecc.err_cnt <= '0;
			ecc.unc <= '0;
		end
		else if (clk_en)
		begin
			if (eng_done)
			begin
				res_op <= cur_op;
				res_fail <= eng_fail;
				if (cur_op == OP_READ)
				begin
					ecc.err_cnt <= eng_err_cnt;
					ecc.unc <= eng_unc;
				end
			end
			else if (start_ok)
				res_op <= OP_NONE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ecc.sel <= '0;
		else if (clk_en)
		begin
			if (cmd_ok && cmd == CMD_ECC_STATUS)
				ecc.sel <= '0;
			else if (mode == M_ECC && re_rise)
				ecc.sel <= ecc.sel + 1'b1;
		end
	end

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[ST_FAIL_BIT] = (res_op == OP_READ) ? ecc.any_unc
			: (res_op != OP_NONE && res_fail);
		status_byte[ST_REWRITE_BIT] =
			(res_op == OP_READ) && ecc.any_rewrite;
		status_byte[ST_RDY_A_BIT] = !busy;
		status_byte[ST_RDY_B_BIT] = !busy;
		status_byte[ST_WP_BIT] = wp_s;
	end

	// Bus driven only while the strobe is low in a status mode
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			io_out <= 8'h00;
			io_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			io_out <= (mode == M_ECC) ? ecc.code_byte : status_byte;
			io_oe <= !ce_n_s && !re_s
				&& (mode == M_STATUS || mode == M_ECC);
		end
	end

	// Open-drain ready line: pulled low while busy
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ready_busy_n_pin_out <= 1'b0;
			ready_busy_n_pin_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			ready_busy_n_pin_out <= 1'b0;
			ready_busy_n_pin_oe <= busy;
		end
	end

	default clocking cb @(posedge clk_sys iff clk_en);
	endclocking
	default disable iff (!rst_n);

	sequence reset_cmd_s;
		cmd_ok && cmd == CMD_RESET && eng_busy;
	endsequence
	sequence abort_pulse_s;
		eng_abort ##1 !eng_abort;
	endsequence

	status_drive_a: assert property (
		mode == M_STATUS && !ce_n_s && !re_s |=> io_oe)
		else $error("status byte not driven");
	ready_bits_a: assert property (
		io_oe && $past(mode) == M_STATUS |->
		io_out[ST_RDY_A_BIT] == io_out[ST_RDY_B_BIT]
		&& io_out[ST_RDY_A_BIT] == !$past(busy))
		else $error("ready bits wrong");
	wp_bit_a: assert property (
		io_oe && $past(mode) == M_STATUS |->
		io_out[ST_WP_BIT] == $past(wp_s))
		else $error("protect bit wrong");
	pe_fail_a: assert property (
		res_op == OP_PROG || res_op == OP_ERASE |->
		status_byte[ST_FAIL_BIT] == res_fail)
		else $error("fail bit wrong");
	pe_rewrite_a: assert property (
		res_op != OP_READ |-> !status_byte[ST_REWRITE_BIT])
		else $error("rewrite bit set outside read");
	busy_status_a: assert property (
		cmd_strobe && cmd == CMD_STATUS |=> mode == M_STATUS)
		else $error("status command not taken");
	ecc_code_a: assert property (
		mode == M_ECC && ecc.unc[ecc.sel] |->
		ecc.code_byte[3:0] == ECC_CODE_UNC)
		else $error("uncorrectable code wrong");
	sector_id_a: assert property (
		mode == M_ECC |-> ecc.code_byte[7:4] == 4'(ecc.sel))
		else $error("sector id wrong");
	reset_abort_a: assert property (
		reset_cmd_s |=> abort_pulse_s)
		else $error("reset did not abort");
	init_guard_a: assert property (
		init_cnt != '0 && cmd_strobe && cmd != CMD_RESET
		&& cmd != CMD_STATUS |=> mode == $past(mode))
		else $error("command taken during init");
	prog_cancel_a: assert property (
		cmd_ok && mode == M_PROG && cmd == CMD_ERASE_SETUP |=>
		mode == M_ERASE && !eng_start)
		else $error("program not cancelled");
	read_resume_a: assert property (
		cmd_ok && cmd == CMD_READ && mode == M_STATUS && rd_resume
		|=> mode == M_RD_DATA)
		else $error("read did not resume");
	wp_inhibit_a: assert property (
		eng_start && eng_op != OP_READ |-> $past(wp_s))
		else $error("program or erase while protected");
endmodule

/* test/nsrcg_host_model.sv */
// Host controller model: command cycles and read strobes on the pins.
// Assumes the device samples pins through synchronisers on clk_sys.
`timescale 1ns/1ps
module nsrcg_host_model (
	input wire logic clk_sys,
	output logic cle,
	output logic ce_n,
	output logic we_n,
	output logic read_strobe_n,
	output logic [7:0] io_in,
	input wire logic [7:0] io_out,
	input wire logic io_oe
);
	initial
	begin
		cle = 1'b0;
		ce_n = 1'b1;
		we_n = 1'b1;
		read_strobe_n = 1'b1;
		io_in = 8'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Four cycles per pin phase so the synchronisers see every level
	// Callers send only listed codes and keep post-80h order legal; t_init sends 80h while busy
	task automatic cmd(input logic [7:0] code);
		@(negedge clk_sys);
		ce_n = 1'b0;
		cle = 1'b1;
		io_in = code;
		we_n = 1'b0;
		hold(4);
		we_n = 1'b1;
		hold(4);
		cle = 1'b0;
		// Released bus shows the inverse so a stale byte is never reused
		io_in = ~code;
	endtask

	task automatic rd(output logic [7:0] d, output logic oe);
		@(negedge clk_sys);
		read_strobe_n = 1'b0;
		hold(4);
		d = io_out;
		oe = io_oe;
		read_strobe_n = 1'b1;
		hold(4);
	endtask
endmodule

/* test/nsrcg_top_tb_top.sv */
// Self-checking bench for the status, reset and command guard.
// Assumes the host model drives pins; the bench acts as the engines.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("unexpected %s exp %0h got %0h", nm, e, g); \
		end \
	end
module nsrcg_top_tb_top;
	import nsrcg_pkg::*;
	logic clk_sys, rst_n, wp_n, eng_busy, eng_done, eng_fail;
	logic [15:0] eng_err_cnt;
	logic [3:0] eng_unc;
	wire cle, ce_n, we_n, read_strobe_n, io_oe, rb_out, rb_oe;
	wire eng_start, eng_abort, rb_line;
	wire [7:0] io_in, io_out;
	nsrcg_op_e eng_op;
	int n_mismatch = 0, num_checks = 0, n_start = 0, n_abort = 0;

	// Open-drain busy line with its pull-up
	assign rb_line = rb_oe ? rb_out : 1'b1;

	nsrcg_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
		.cle(cle), .ce_n(ce_n), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .ready_busy_n_pin_out(rb_out),
		.ready_busy_n_pin_oe(rb_oe), .eng_busy(eng_busy),
		.eng_done(eng_done), .eng_fail(eng_fail),
		.eng_err_cnt(eng_err_cnt), .eng_unc(eng_unc),
		.eng_start(eng_start), .eng_op(eng_op), .eng_abort(eng_abort));

	nsrcg_host_model u_host (.clk_sys(clk_sys), .cle(cle), .ce_n(ce_n),
		.we_n(we_n), .read_strobe_n(read_strobe_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));

	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Pulses are counted here since commands take longer than a pulse
	always @(posedge clk_sys)
	begin
		if (eng_start === 1'b1)
			n_start++;
		if (eng_abort === 1'b1)
			n_abort++;
	end

	task automatic wrap_up;
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic st(input logic [7:0] e);
		logic [7:0] d;
		logic oe;
		u_host.rd(d, oe);
		`CHK("io_oe", 1'b1, oe)
		`CHK("status", e, d)
	endtask

	// Engine side: result valid only with the done pulse, garbage after
	task automatic fin(input logic f, input logic [15:0] c,
		input logic [3:0] u);
		@(negedge clk_sys);
		eng_busy = 1'b0;
		eng_done = 1'b1;
		eng_fail = f;
		eng_err_cnt = c;
		eng_unc = u;
		@(negedge clk_sys);
		eng_done = 1'b0;
		eng_fail = ~f;
		eng_err_cnt = ~c;
		eng_unc = ~u;
		u_host.hold(2);
	endtask

	task automatic start_op(input logic [7:0] a, input logic [7:0] b,
		input nsrcg_op_e op);
		int n0;
		n0 = n_start;
		u_host.cmd(a);
		u_host.cmd(b);
		`CHK("eng_start", n0 + 1, n_start)
		`CHK("eng_op", op, eng_op)
		eng_busy = 1'b1;
	endtask

	task automatic t_init;
		`CHK("rb_line", 1'b0, rb_line)
		u_host.cmd(CMD_STATUS);
		st(8'h80);
		// Still in the init window: this code must leave status mode alone
		u_host.cmd(CMD_SERIAL_IN);
		st(8'h80);
		u_host.hold(INIT_CYCLES);
		`CHK("rb_line", 1'b1, rb_line)
		st(8'hE0);
	endtask

	task automatic t_prog;
		u_host.cmd(CMD_SERIAL_IN);
		start_op(CMD_COL_CHG, CMD_PROG_GO, OP_PROG);
		u_host.cmd(CMD_STATUS);
		st(8'h80);
		`CHK("rb_line", 1'b0, rb_line)
		fin(1'b1, 16'h0000, 4'h0);
		st(8'hE1);
		start_op(CMD_ERASE_SETUP, CMD_ERASE_GO, OP_ERASE);
		u_host.cmd(CMD_STATUS);
		fin(1'b0, 16'h7777, 4'h0);
		st(8'hE0);
	endtask

	// Read with status during busy, resume by 00h, then ECC bytes
	task automatic do_read(input logic [7:0] go, input logic [15:0] c,
		input logic [3:0] u, input logic [7:0] s, input logic [31:0] e);
		logic [7:0] d;
		logic oe;
		int n0;
		start_op(CMD_READ, go, OP_READ);
		u_host.cmd(CMD_STATUS);
		st(8'h80);
		fin(1'b0, c, u);
		st(s);
		n0 = n_start;
		u_host.cmd(CMD_READ);
		u_host.rd(d, oe);
		`CHK("io_oe", 1'b0, oe)
		`CHK("eng_start", n0, n_start)
		u_host.cmd(CMD_ECC_STATUS);
		for (int i = 0; i < 5; i++)
		begin
			u_host.rd(d, oe);
			`CHK("ecc", e[8*(i%4)+:8], d)
		end
	endtask

	task automatic t_abort;
		int n0;
		u_host.cmd(CMD_SERIAL_IN);
		start_op(CMD_COL_CHG, CMD_PROG_GO, OP_PROG);
		n0 = n_abort;
		u_host.cmd(CMD_RESET);
		`CHK("eng_abort", n0 + 1, n_abort)
		eng_busy = 1'b0;
		u_host.cmd(CMD_STATUS);
		st(8'hE0);
		u_host.cmd(CMD_SERIAL_IN);
		start_op(CMD_ERASE_SETUP, CMD_ERASE_GO, OP_ERASE);
		fin(1'b0, 16'h0000, 4'h0);
	endtask

	task automatic t_wp;
		int n0;
		wp_n = 1'b0;
		u_host.cmd(CMD_STATUS);
		st(8'h60);
		n0 = n_start;
		u_host.cmd(CMD_SERIAL_IN);
		u_host.cmd(CMD_PROG_GO);
		u_host.cmd(CMD_ERASE_SETUP);
		u_host.cmd(CMD_ERASE_GO);
		`CHK("eng_start", n0, n_start)
		wp_n = 1'b1;
		u_host.cmd(CMD_SERIAL_IN);
		start_op(CMD_COL_CHG, CMD_PROG_GO, OP_PROG);
		n0 = n_abort;
		wp_n = 1'b0;
		u_host.hold(8);
		`CHK("eng_abort", n0 + 1, n_abort)
		eng_busy = 1'b0;
		wp_n = 1'b1;
	endtask

	initial
	begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		eng_busy = 1'b0;
		eng_done = 1'b0;
		eng_fail = 1'b0;
		eng_err_cnt = 16'h0000;
		eng_unc = 4'h0;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		t_init;
		t_prog;
		do_read(CMD_READ_GO, 16'h3860, 4'h8, 8'hE9, 32'h3F281600);
		do_read(CMD_CB_READ, 16'h2015, 4'h0, 8'hE0, 32'h32201105);
		t_abort;
		t_wp;
		wrap_up;
	end

	// The sequence needs about 620 cycles; some twenty-four times that is a hang
	initial
	begin
		repeat (15000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up;
	end
endmodule
